// *** hw/probe_cmd_pkg.sv ***
// constants and decode helpers shared by both ends of the inbound probe command link
// Function
// - first-cycle bit 14: probe or transfer
// - probes take four cycles, all collected
// - fixed probe field layout over four cycles
// - bits 1..0 carry address bits 35..42
// - victim release clears named buffer valid
// - probe release clears probe valid bit
// - acknowledge decrements outstanding command count
// - index bit 3 marks io write buffer
// - commit decrements uncommitted event counter
// - upper type bits select data movement
// - lower type bits select next state
// - eight-entry probe queue, sender never overruns
// - entry freed when response is sent, or after the lookup on a miss
// - full block read by default
// - tag-only mode: hit retries for data
// - hit history fetches data with tag
// - embedded data-movement code also acted on
// - data-movement code zero is ignored
// - probe ahead of its movement command
// - hits answered with five-cycle response 00001
`default_nettype none
package probe_cmd_pkg;
  localparam int CMD_W = 15;
  localparam int PA_W = 40;
  localparam int PQ_DEPTH = 8;
  localparam int BIT_TYPE = 14;
  localparam int BIT_COMMIT = 14;
  localparam int BIT_RVB = 8;
  localparam int BIT_RPB = 7;
  localparam int BIT_ACK = 6;
  localparam logic [1:0] LAST_PROBE_CYC = 2'h3;
  localparam logic [1:0] LAST_XFER_CYC = 2'h1;
  localparam logic [2:0] RESP_CYCLES = 3'h4;
  localparam logic [4:0] DM_NOP = 5'h00;
  localparam logic [4:0] DM_MB_DONE = 5'h06;
  localparam logic [4:0] RESP_CMD = 5'h01;
  // tag status as reported in a response
  localparam logic [1:0] ST_CLEAN = 2'h0;
  localparam logic [1:0] ST_SHARED = 2'h1;
  localparam logic [1:0] ST_DIRTY = 2'h2;
  localparam logic [1:0] ST_SHDIRTY = 2'h3;
  localparam logic [1:0] MV_HIT = 2'h1;
  localparam logic [1:0] MV_DIRTY = 2'h2;
  localparam logic [1:0] MV_ANY = 2'h3;
  localparam logic [2:0] NX_CLEAN = 3'h1;
  localparam logic [2:0] NX_CSHARED = 3'h2;
  localparam logic [2:0] NX_TRANS3 = 3'h3;
  localparam logic [2:0] NX_DSHARED = 3'h4;
  localparam logic [2:0] NX_INVAL = 3'h5;
  localparam logic [2:0] NX_TRANS1 = 3'h6;
  // link timing: bench link period over the ref clock period
  localparam int REF_PERIOD_NS = 4;
  localparam int LINK_PERIOD_NS = 32;
  localparam int LINK_HALF_CYC = LINK_PERIOD_NS / REF_PERIOD_NS / 2;
  // controller register map (apb byte offsets) and field positions
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_ADDR_LO = 8'h04;
  localparam logic [7:0] OFF_ADDR_HI = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0C;
  localparam logic [7:0] OFF_RESP = 8'h10;
  localparam int CMD_REG_W = 19;
  localparam int BIT_GO = 0;
  localparam int BIT_CREDIT = 1;
  localparam int BIT_REFUSED = 2;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // next {valid, status} of a probed block; misses stay invalid
  function automatic logic [2:0] next_tag(input logic [2:0] code, input logic hit,
                                          input logic [1:0] st);
    logic [2:0] cur;
    cur = {hit, st};
    next_tag = cur;
    if (hit)
    begin
      case (code)
        NX_CLEAN: next_tag = {1'b1, ST_CLEAN};
        NX_CSHARED: next_tag = {1'b1, ST_SHARED};
        NX_DSHARED: next_tag = {1'b1, ST_SHDIRTY};
        NX_INVAL: next_tag = 3'h0;
        NX_TRANS3: next_tag = (st == ST_DIRTY) ? 3'h0 : {1'b1, ST_SHARED};
        NX_TRANS1: next_tag = (st == ST_DIRTY) ? {1'b1, ST_SHDIRTY} :
                              (st == ST_CLEAN) ? {1'b1, ST_SHARED} : cur;
        default: next_tag = cur; // nop and reserved code
      endcase
    end
  endfunction : next_tag

  // whether the block is handed to the system
  function automatic logic must_supply(input logic [1:0] mv, input logic hit,
                                       input logic [1:0] st);
    case (mv)
      MV_HIT: must_supply = hit;
      MV_DIRTY: must_supply = hit & st[1];
      MV_ANY: must_supply = 1'b1;
      default: must_supply = 1'b0;
    endcase
  endfunction : must_supply
endpackage : probe_cmd_pkg
`default_nettype wire

// *** hw/probe_link_if.sv ***
// link between system controller and processor command port
`default_nettype none
interface probe_link_if;
  logic link_clk;
  logic [14:0] inbound_command_bus;
  logic [14:0] outbound_command_bus;
  modport dev (input link_clk, input inbound_command_bus, output outbound_command_bus);
  modport sys (output link_clk, output inbound_command_bus, input outbound_command_bus);
endinterface : probe_link_if
`default_nettype wire

// *** hw/probe_cmd_device.sv ***
// processor end: receives inbound probe and transfer commands, queues and executes the probes, acts on transfers at once
`default_nettype none
module probe_cmd_device
  import probe_cmd_pkg::*;
#(
  parameter int DEPTH = PQ_DEPTH,
  parameter int CNT_W = 5,
  parameter int HIST_W = 2,
  parameter int HIT_HIST_THRESH = 2
)
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  probe_link_if.dev link,
  input wire logic probe_tag_only_mode,
  input wire logic [4:0] outstanding_command_limit,
  input wire logic cmd_sent,
  input wire logic event_issue,
  output logic lookup_req_ff,
  output logic [PA_W-1:0] lookup_addr_ff,
  output logic lookup_full_ff,
  input wire logic lookup_done,
  input wire logic lookup_hit,
  input wire logic [1:0] lookup_status,
  output logic tag_update_ff,
  output logic [2:0] next_tag_ff,
  output logic supply_data_ff,
  output logic buf_release_ff,
  output logic [3:0] buf_release_idx_ff,
  output logic [DEPTH-1:0] probe_valid_ff,
  output logic [CNT_W-1:0] outstanding_cnt_ff,
  output logic cmd_stall_ff,
  output logic [CNT_W-1:0] uncommitted_cnt_ff,
  output logic dm_valid_ff,
  output logic [4:0] dm_code_ff,
  output logic mb_done_ff
);
  localparam int QW = $clog2(DEPTH);

  if (DEPTH < 2 || DEPTH > 8 || (1 << QW) != DEPTH || CNT_W < 5 || HIST_W < 1)
  begin : g_check
    $error("probe_cmd_device: unsupported parameter values");
  end

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_LOOK = 4'b0010,
    S_RESP = 4'b0100,
    S_DONE = 4'b1000
  } pstate_type;

  // saturating up/down count step
  function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] c,
                                                input logic inc, input logic dec);
    cnt_step = c;
    if (inc && !dec && c != {CNT_W{1'b1}})
      cnt_step = c + 1'b1;
    else if (dec && !inc && c != '0)
      cnt_step = c - 1'b1;
  endfunction : cnt_step

  // link synchronisers; edges are found on the second stage only
  logic clk_s1_ff, clk_s2_ff, clk_s3_ff;
  logic [14:0] bus_s1_ff, bus_s2_ff;
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      clk_s1_ff <= 1'b0;
      clk_s2_ff <= 1'b0;
      clk_s3_ff <= 1'b0;
      bus_s1_ff <= '0;
      bus_s2_ff <= '0;
    end
    else if (clk_en)
    begin
      clk_s1_ff <= link.link_clk;
      clk_s2_ff <= clk_s1_ff;
      clk_s3_ff <= clk_s2_ff;
      bus_s1_ff <= link.inbound_command_bus;
      bus_s2_ff <= bus_s1_ff;
    end
  end
  wire link_rise = clk_s2_ff & ~clk_s3_ff;

  // command framing: type fixed by first cycle, probes held until all four cycles are in
  logic [1:0] in_cnt_ff;
  logic in_probe_ff;
  logic [14:0] w0_ff, w1_ff, w2_ff;
  wire first_cyc = (in_cnt_ff == 2'h0);
  wire is_probe = first_cyc ? bus_s2_ff[BIT_TYPE] : in_probe_ff;
  wire act = link_rise && (in_cnt_ff == (is_probe ? LAST_PROBE_CYC : LAST_XFER_CYC));
  wire act_probe = act & in_probe_ff;
  wire act_xfer = act & ~in_probe_ff;
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      in_cnt_ff <= 2'h0;
      in_probe_ff <= 1'b0;
    end
    else if (clk_en && link_rise)
    begin
      in_cnt_ff <= act ? 2'h0 : in_cnt_ff + 2'h1;
      in_probe_ff <= is_probe;
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (clk_en && link_rise)
    begin
      if (in_cnt_ff == 2'h0)
        w0_ff <= bus_s2_ff;
      if (in_cnt_ff == 2'h1)
        w1_ff <= bus_s2_ff;
      if (in_cnt_ff == 2'h2)
        w2_ff <= bus_s2_ff;
    end
  end

  // field extraction; transfers carry the release fields in their first cycle
  wire [14:0] fw = in_probe_ff ? w2_ff : w0_ff;
  wire [4:0] f_dm = fw[13:9];
  wire [3:0] f_id = fw[5:2];
  wire f_rvb = fw[BIT_RVB];
  wire f_rpb = fw[BIT_RPB];
  wire f_ack = fw[BIT_ACK];
  wire f_commit = bus_s2_ff[BIT_COMMIT];
  wire [PA_W-1:0] in_addr = {w2_ff[0], bus_s2_ff[0], w2_ff[1], bus_s2_ff[1], w0_ff[0], w1_ff[0],
    w0_ff[1], w1_ff[1], w0_ff[8:2], w1_ff[14:9], bus_s2_ff[13:5], w1_ff[8:2],
    bus_s2_ff[4:2]};

  // probe queue; an overrun by the sender is dropped, it must count its probes
  logic [PA_W-1:0] q_addr [DEPTH];
  logic [4:0] q_type [DEPTH];
  logic [4:0] q_dm [DEPTH];
  logic [QW-1:0] head_ff, tail_ff;
  logic [QW:0] count_ff;
  pstate_type st_ff;
  wire q_full = (count_ff == (QW+1)'(DEPTH));
  wire enq = act_probe & ~q_full;
  wire deq = (st_ff == S_DONE) & ~act; // done waits a cycle if any command is decoded
  always_ff @(posedge ref_clk)
  begin
    if (clk_en && enq)
    begin
      q_addr[tail_ff] <= in_addr;
      q_type[tail_ff] <= w0_ff[13:9];
      q_dm[tail_ff] <= f_dm;
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      head_ff <= '0;
      tail_ff <= '0;
      count_ff <= '0;
    end
    else if (clk_en)
    begin
      tail_ff <= tail_ff + QW'(enq);
      head_ff <= head_ff + QW'(deq); // entry freed once its response went out, or right after the lookup on a miss
      count_ff <= count_ff + (QW+1)'(enq) - (QW+1)'(deq);
    end
  end

  // probe execution
  wire [4:0] h_type = q_type[head_ff];
  wire [4:0] h_dm = q_dm[head_ff];
  logic [HIST_W-1:0] hist_ff;
  wire hist_hot = (hist_ff >= HIST_W'(HIT_HIST_THRESH));
  wire sup = must_supply(h_type[4:3], lookup_hit, lookup_status);
  wire retry = ~lookup_full_ff & lookup_hit; // tag-only hit: go again for the data
  logic retry_ff, sup_ff;
  logic [2:0] out_cnt_ff;
  logic [14:0] resp_ff, out_word_ff;
  assign link.outbound_command_bus = out_word_ff;
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      st_ff <= S_IDLE;
      lookup_req_ff <= 1'b0;
      lookup_addr_ff <= '0;
      lookup_full_ff <= 1'b1;
      retry_ff <= 1'b0;
      sup_ff <= 1'b0;
      tag_update_ff <= 1'b0;
      next_tag_ff <= 3'h0;
      supply_data_ff <= 1'b0;
      resp_ff <= '0;
      out_word_ff <= '0;
      out_cnt_ff <= 3'h0;
    end
    else if (clk_en)
    begin
      tag_update_ff <= 1'b0;
      unique case (st_ff)
        S_IDLE:
          if (count_ff != '0)
          begin
            lookup_req_ff <= 1'b1;
            lookup_addr_ff <= q_addr[head_ff];
            // full read unless tag-only; history or a retry brings the data along
            lookup_full_ff <= ~probe_tag_only_mode | retry_ff | hist_hot;
            st_ff <= S_LOOK;
          end
        S_LOOK:
          if (lookup_done)
          begin
            lookup_req_ff <= 1'b0;
            retry_ff <= retry;
            if (retry)
              st_ff <= S_IDLE;
            else
            begin
              tag_update_ff <= lookup_hit;
              next_tag_ff <= next_tag(h_type[2:0], lookup_hit, lookup_status);
              supply_data_ff <= sup;
              sup_ff <= sup;
              resp_ff <= {1'b0, RESP_CMD, lookup_status, sup, 1'b0, 3'(head_ff), 2'h0};
              st_ff <= lookup_hit ? S_RESP : S_DONE;
            end
          end
        S_RESP:
          if (link_rise)
          begin
            // word then four empty cycles, one per link cycle
            out_word_ff <= (out_cnt_ff == 3'h0) ? resp_ff : '0;
            out_cnt_ff <= (out_cnt_ff == RESP_CYCLES) ? 3'h0 : out_cnt_ff + 3'h1;
            if (out_cnt_ff == RESP_CYCLES)
              st_ff <= S_DONE;
          end
        S_DONE:
          if (deq)
          begin
            sup_ff <= 1'b0;
            st_ff <= S_IDLE;
          end
      endcase
    end
  end

  // hit history, only trained while tag-only mode is set
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      hist_ff <= '0;
    else if (clk_en && st_ff == S_LOOK && lookup_done && probe_tag_only_mode)
    begin
      if (lookup_hit && hist_ff != {HIST_W{1'b1}})
        hist_ff <= hist_ff + 1'b1;
      else if (!lookup_hit && hist_ff != '0)
        hist_ff <= hist_ff - 1'b1;
    end
  end

  // buffer releases, counters and probe valid bits; a set wins over a clear
  wire [DEPTH-1:0] pv_clr = (act & f_rpb) ? (DEPTH'(1) << f_id[QW-1:0]) : '0;
  wire [DEPTH-1:0] pv_set = (deq & sup_ff) ? (DEPTH'(1) << head_ff) : '0;
  wire [CNT_W-1:0] nxt_outstanding = cnt_step(outstanding_cnt_ff, cmd_sent, act & f_ack);
  wire [CNT_W-1:0] nxt_uncommitted = cnt_step(uncommitted_cnt_ff, event_issue,
                                              act & f_commit);
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      buf_release_ff <= 1'b0;
      buf_release_idx_ff <= 4'h0;
      probe_valid_ff <= '0;
      outstanding_cnt_ff <= '0;
      uncommitted_cnt_ff <= '0;
      cmd_stall_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      buf_release_ff <= act & f_rvb;
      if (act)
        buf_release_idx_ff <= f_id; // bit 3 set means io write buffer
      probe_valid_ff <= (probe_valid_ff & ~pv_clr) | pv_set;
      outstanding_cnt_ff <= nxt_outstanding;
      uncommitted_cnt_ff <= nxt_uncommitted;
      cmd_stall_ff <= (outstanding_command_limit != 5'h00) &&
                      (nxt_outstanding >= CNT_W'(outstanding_command_limit));
    end
  end

  // data-movement commands; a probe's own code waits until that probe has executed
  wire emit_x = act_xfer & (f_dm != DM_NOP);
  wire emit_p = deq & (h_dm != DM_NOP);
  wire mb_set = (act_xfer & (f_dm == DM_MB_DONE)) | (deq & (h_dm == DM_MB_DONE));
  logic mb_pend_ff;
  wire mb_fire = mb_pend_ff & (uncommitted_cnt_ff == '0);
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      dm_valid_ff <= 1'b0;
      dm_code_ff <= DM_NOP;
      mb_pend_ff <= 1'b0;
      mb_done_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      dm_valid_ff <= emit_x | emit_p;
      if (emit_x | emit_p)
        dm_code_ff <= emit_x ? f_dm : h_dm;
      mb_pend_ff <= (mb_pend_ff & ~mb_fire) | mb_set;
      mb_done_ff <= mb_fire;
    end
  end
endmodule : probe_cmd_device
`default_nettype wire

// *** hw/probe_cmd_system.sv ***
// system controller end: apb-programmed sender of probes and transfer commands
`default_nettype none
module probe_cmd_system
  import probe_cmd_pkg::*;
#(
  parameter int HALF = LINK_HALF_CYC,
  parameter int DEPTH = PQ_DEPTH
)
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  probe_link_if.sys link
);
  if (HALF < 4 || HALF > 255 || DEPTH < 1 || DEPTH > 15)
  begin : g_check
    $error("probe_cmd_system: unsupported parameter values");
  end

  logic [CMD_REG_W-1:0] cmd_ff;
  logic [31:0] addr_lo_ff;
  logic [10:0] addr_hi_ff;
  logic go_ff, refused_ff;
  logic [3:0] inflight_ff;
  logic [14:0] resp_ff;
  logic [15:0] resp_cnt_ff;

  // divider makes the link clock; the bus moves on its falling half
  logic [7:0] div_ff;
  logic link_clk_ff;
  wire half_end = (div_ff == 8'(HALF - 1));
  wire fall = half_end & link_clk_ff;
  wire rise = half_end & ~link_clk_ff;
  assign link.link_clk = link_clk_ff;

  // frame words from the command registers
  wire [42:3] pa = {addr_hi_ff, addr_lo_ff[31:3]};
  wire c_probe = cmd_ff[0];
  wire [14:0] rel = {1'b0, cmd_ff[10:6], cmd_ff[11], cmd_ff[12], cmd_ff[13], cmd_ff[17:14],
                     2'h0};
  wire [14:0] pw0 = {1'b1, cmd_ff[5:1], pa[34:28], pa[36], pa[38]};
  wire [14:0] pw1 = {pa[27:22], pa[12:6], pa[35], pa[37]};
  wire [14:0] pw2 = {rel[14:2], pa[40], pa[42]};
  wire [14:0] pw3 = {cmd_ff[18], pa[21:13], pa[5:3], pa[39], pa[41]};
  wire [14:0] xw1 = {cmd_ff[18], 14'h0000};

  // sender: idle time is a stream of two-cycle no-op transfers
  logic [1:0] cyc_ff, last_ff;
  logic [14:0] bus_ff;
  logic [44:0] sh_ff;
  wire start = fall & (cyc_ff == last_ff);
  wire launch = start & go_ff;
  assign link.inbound_command_bus = bus_ff;
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      div_ff <= 8'h00;
      link_clk_ff <= 1'b0;
      cyc_ff <= 2'h0;
      last_ff <= LAST_XFER_CYC;
      bus_ff <= '0;
      sh_ff <= '0;
    end
    else if (clk_en)
    begin
      div_ff <= half_end ? 8'h00 : div_ff + 8'h01;
      if (half_end)
        link_clk_ff <= ~link_clk_ff;
      if (start)
      begin
        cyc_ff <= 2'h0;
        last_ff <= (launch & c_probe) ? LAST_PROBE_CYC : LAST_XFER_CYC;
        bus_ff <= launch ? (c_probe ? pw0 : rel) : '0;
        sh_ff <= launch ? (c_probe ? {pw1, pw2, pw3} : {xw1, 30'h0000_0000}) : '0;
      end
      else if (fall)
      begin
        cyc_ff <= cyc_ff + 2'h1;
        bus_ff <= sh_ff[44:30];
        sh_ff <= {sh_ff[29:0], 15'h0000};
      end
    end
  end

  // response receiver on synchronised outbound bus
  logic [14:0] out_s1_ff, out_s2_ff;
  logic [1:0] rskip_ff;
  wire got_resp = rise & (rskip_ff == 2'h0) & ~out_s2_ff[14] & (out_s2_ff[13:9] == RESP_CMD);
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      out_s1_ff <= '0;
      out_s2_ff <= '0;
      rskip_ff <= 2'h0;
      resp_ff <= '0;
      resp_cnt_ff <= 16'h0000;
    end
    else if (clk_en)
    begin
      out_s1_ff <= link.outbound_command_bus;
      out_s2_ff <= out_s1_ff;
      if (got_resp)
      begin
        rskip_ff <= LAST_PROBE_CYC;
        resp_ff <= out_s2_ff;
        resp_cnt_ff <= resp_cnt_ff + 16'h0001;
      end
      else if (rise && rskip_ff != 2'h0)
        rskip_ff <= rskip_ff - 2'h1;
    end
  end

  // apb slave: one wait state, answer in the second access cycle
  wire apb_done = psel & penable & pready_ff;
  wire mapped = (paddr == OFF_CMD) | (paddr == OFF_ADDR_LO) | (paddr == OFF_ADDR_HI) |
                (paddr == OFF_CTRL) | (paddr == OFF_RESP);
  wire wr = apb_done & pwrite & mapped;
  wire wr_ctrl = wr & (paddr == OFF_CTRL);
  wire full_q = (inflight_ff == 4'(DEPTH));
  wire go_req = wr_ctrl & pwdata[BIT_GO];
  wire go_bad = go_req & (go_ff | (c_probe & full_q)); // never overrun the queue
  wire credit = wr_ctrl & pwdata[BIT_CREDIT] & (inflight_ff != 4'h0);
  wire [3:0] inflight_dn = {3'h0, got_resp & (inflight_ff != 4'h0)} + {3'h0, credit};
  wire [31:0] rdata = (paddr == OFF_CMD) ? {13'h0000, cmd_ff} :
                      (paddr == OFF_ADDR_LO) ? addr_lo_ff :
                      (paddr == OFF_ADDR_HI) ? {21'h00_0000, addr_hi_ff} :
                      (paddr == OFF_CTRL) ? {24'h00_0000, inflight_ff, 2'h0, refused_ff, go_ff} :
                      (paddr == OFF_RESP) ? {resp_cnt_ff, 1'b0, resp_ff} : RESET_WORD;
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= RESET_WORD;
      cmd_ff <= '0;
      addr_lo_ff <= RESET_WORD;
      addr_hi_ff <= '0;
      go_ff <= 1'b0;
      refused_ff <= 1'b0;
      inflight_ff <= 4'h0;
    end
    else if (clk_en)
    begin
      pready_ff <= psel & penable & ~pready_ff;
      pslverr_ff <= psel & penable & ~pready_ff & ~mapped;
      if (psel & penable & ~pready_ff)
        prdata_ff <= pwrite ? RESET_WORD : rdata;
      if (wr && paddr == OFF_CMD)
        cmd_ff <= pwdata[CMD_REG_W-1:0];
      if (wr && paddr == OFF_ADDR_LO)
        addr_lo_ff <= pwdata;
      if (wr && paddr == OFF_ADDR_HI)
        addr_hi_ff <= pwdata[10:0];
      go_ff <= (go_ff & ~launch) | (go_req & ~go_bad);
      refused_ff <= (refused_ff & ~(wr_ctrl & pwdata[BIT_REFUSED])) | go_bad;
      inflight_ff <= inflight_ff + {3'h0, launch & c_probe} - inflight_dn;
    end
  end
endmodule : probe_cmd_system
`default_nettype wire

// *** verification/probe_link_properties.sv ***
// concurrent checks on the inbound and outbound command link
`default_nettype none
module probe_link_properties
  import probe_cmd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic link_clk,
  input wire logic [14:0] inbound_command_bus,
  input wire logic [14:0] outbound_command_bus
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire logic lc = link_clk;
  wire logic [14:0] ib = inbound_command_bus;
  wire logic [14:0] ob = outbound_command_bus;
  logic lq_ff, prb_ff;
  logic [1:0] left_ff;
  wire logic rise = lc & ~lq_ff;
  wire logic start = left_ff == 2'h0;
  // link cycles left in the frame, so each cycle's layout is known
  always_ff @(posedge ref_clk)
  begin
    lq_ff <= lc & ~srst;
    left_ff <= srst ? 2'h0 : !rise ? left_ff : start ? {ib[14], 1'b1} : left_ff - 2'h1;
    if (rise & start)
      prb_ff <= ib[14];
  end
  a_clk_high: assert property ($rose(lc) |-> lc [*4] ##1 !lc)
    else $error("link clock high phase wrong");
  a_clk_low: assert property ($fell(lc) |-> !lc [*4] ##1 lc)
    else $error("link clock low phase wrong");
  a_bus_hold: assert property (lc && $past(lc) |-> $stable(ib))
    else $error("command word moved while link clock high");
  a_cyc3_marker: assert property (rise && prb_ff && left_ff == 2'h2 |-> !ib[14])
    else $error("probe third cycle marker not zero");
  a_xfer_tail: assert property (rise && !prb_ff && left_ff == 2'h1 |-> ib[13:0] == 14'h0000)
    else $error("transfer second cycle not clean");
  a_resp_code: assert property (ob != 15'h0000 |-> ob[14:9] == {1'b0, RESP_CMD} && !ob[5])
    else $error("response word has wrong code");
  a_resp_hold: assert property ($changed(ob) |=> $stable(ob) [*7])
    else $error("response word not held a link period");
  a_resp_tail: assert property ($changed(ob) && ob != 15'h0000 |->
    ##8 ob == 15'h0000 ##8 ob == 15'h0000 ##8 ob == 15'h0000)
    else $error("response not followed by three empty cycles");
endmodule : probe_link_properties
`default_nettype wire

// *** verification/test_system_probe_command_receiver.sv ***
// bench: apb-programmed sender driving the device end over the link
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  $display("MISMATCH %s expected %0h seen %0h", n, e, g); err_total++; end end
module test_system_probe_command_receiver
  import probe_cmd_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, srst = 1'b1, clk_en = 1'b1, lookup_hit = 1'b1, lookup_done = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cmd_sent = 1'b0, event_issue = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic probe_tag_only_mode = 1'b0;
  logic [4:0] outstanding_command_limit = 5'h00;
  logic [1:0] lookup_status = 2'h0;
  logic [31:0] prdata_ff, q;
  logic pready_ff, pslverr_ff, slverr, lookup_req_ff, lookup_full_ff, tag_update_ff;
  logic supply_data_ff, buf_release_ff, cmd_stall_ff, dm_valid_ff, mb_done_ff;
  logic [39:0] lookup_addr_ff, got_addr;
  logic [2:0] next_tag_ff, got_tag, k;
  logic [3:0] buf_release_idx_ff, got_rel;
  logic [7:0] probe_valid_ff;
  logic [4:0] outstanding_cnt_ff, uncommitted_cnt_ff, dm_code_ff, got_dm, dm;
  logic [1:0] full_hist, st;
  logic [42:0] pa;
  logic [7:0][2:0] exp_nt = {3'h4, 3'h5, 3'h0, 3'h7, 3'h0, 3'h5, 3'h4, 3'h6};
  logic [7:0] exp_sup = 8'hAE;
  int err_total = 0, total_checks = 0, n_req = 0, n_dm = 0, n_resp = 0, n_mb = 0, n0;
  probe_link_if lnk ();
  probe_cmd_system i_probe_cmd_system (.ref_clk, .srst, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata_ff, .pready_ff, .pslverr_ff, .link(lnk.sys));
  probe_cmd_device i_probe_cmd_device (.ref_clk, .srst, .clk_en, .link(lnk.dev),
    .probe_tag_only_mode, .outstanding_command_limit, .cmd_sent, .event_issue,
    .lookup_req_ff, .lookup_addr_ff, .lookup_full_ff, .lookup_done, .lookup_hit,
    .lookup_status, .tag_update_ff, .next_tag_ff, .supply_data_ff, .buf_release_ff,
    .buf_release_idx_ff, .probe_valid_ff, .outstanding_cnt_ff, .cmd_stall_ff,
    .uncommitted_cnt_ff, .dm_valid_ff, .dm_code_ff, .mb_done_ff);
  probe_link_properties i_probe_link_properties (.ref_clk, .srst, .link_clk(lnk.link_clk),
    .inbound_command_bus(lnk.inbound_command_bus),
    .outbound_command_bus(lnk.outbound_command_bus));
  initial forever #2 ref_clk = ~ref_clk;
  // cache stand-in answers each lookup a cycle later; monitor keeps the last results
  always @(posedge ref_clk)
  begin
    lookup_done <= lookup_req_ff & ~lookup_done;
    if (lookup_done)
    begin
      n_req <= n_req + 1;
      full_hist <= {full_hist[0], lookup_full_ff};
      got_addr <= lookup_addr_ff;
    end
    if (tag_update_ff)
      got_tag <= next_tag_ff;
    if (buf_release_ff)
      got_rel <= buf_release_idx_ff;
    if (mb_done_ff)
      n_mb <= n_mb + 1;
    if (dm_valid_ff)
    begin
      n_dm <= n_dm + 1;
      got_dm <= dm_code_ff;
    end
  end
  // one apb transfer; only the watchdog bounds the wait for pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready_ff !== 1'b1);
    q = prdata_ff;
    slverr = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  // program and launch a command; a probe also waits for its response count
  task automatic send(input logic [18:0] c);
    apb(1'b1, OFF_ADDR_LO, pa[31:0]);
    apb(1'b1, OFF_ADDR_HI, {21'h0, pa[42:32]});
    apb(1'b1, OFF_CMD, {13'h0, c});
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    n_resp = n_resp + c[0];
    while (c[0] && q[31:16] !== n_resp[15:0])
      apb(1'b0, OFF_RESP, 32'h0000_0000);
  endtask : send
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial
  begin
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    `CHK("full read", 1'b1, lookup_full_ff)
    apb(1'b0, OFF_RESP, 32'h0000_0000);
    `CHK("resp reset", RESET_WORD, q)
    apb(1'b0, 8'hFC, 32'h0000_0000);
    `CHK("unmapped", 1'b1, slverr)
    // every next-state code and movement kind, block dirty then clean
    for (int i = 0; i < 8; i++)
    begin
      k = i[2:0];
      st = k[2] ? ST_CLEAN : ST_DIRTY;
      dm = (i == 0) ? DM_NOP : {2'b10, k};
      pa = {k, 40'h12_3456_78A8};
      lookup_status <= st;
      send({8'h00, dm, k[1:0], k, 1'b1});
      `CHK("addr", pa[42:3], got_addr)
      `CHK("next tag", exp_nt[k], got_tag)
      `CHK("supply", exp_sup[k], supply_data_ff)
      `CHK("resp", {1'b0, RESP_CMD, st, exp_sup[k]}, q[14:6])
    end
    `CHK("lookups", 8, n_req)
    // three commands out and two events, then a probe acks, commits and releases
    outstanding_command_limit <= 5'h03;
    cmd_sent <= 1'b1;
    event_issue <= 1'b1;
    repeat (2) @(posedge ref_clk);
    event_issue <= 1'b0;
    @(posedge ref_clk);
    cmd_sent <= 1'b0;
    repeat (2) @(posedge ref_clk);
    `CHK("stall", 1'b1, cmd_stall_ff)
    send({1'b1, 4'hA, 3'h7, DM_NOP, 5'h01, 1'b1});
    `CHK("released", 4'hA, got_rel)
    `CHK("probe valid", 1'b0, probe_valid_ff[2])
    `CHK("outstanding", 5'h02, outstanding_cnt_ff)
    `CHK("uncommitted", 5'h01, uncommitted_cnt_ff)
    `CHK("dm count", 7, n_dm)
    `CHK("dm code", 5'h17, got_dm)
    // transfer command acks and carries a code without any lookup
    send({1'b0, 4'h0, 3'h4, 5'h04, 5'h00, 1'b0});
    while (n_dm != 8)
      @(posedge ref_clk);
    @(posedge ref_clk);
    `CHK("xfer code", 5'h04, got_dm)
    `CHK("xfer ack", 5'h01, outstanding_cnt_ff)
    // barrier done held until commits drain
    send({8'h00, 5'h06, 6'h00});
    repeat (48) @(posedge ref_clk);
    `CHK("mb held", 0, n_mb)
    send({1'b1, 7'h00, DM_NOP, 6'h00});
    repeat (48) @(posedge ref_clk);
    `CHK("mb done", 1, n_mb)
    // tag-only lookup: a hit comes back once more for the whole block
    probe_tag_only_mode <= 1'b1;
    n0 = n_req;
    send({8'h00, DM_NOP, 5'h08, 1'b1});
    `CHK("retry", n0 + 2, n_req)
    `CHK("tag then full", 2'b01, full_hist)
    n0 = n_req;
    send({8'h00, DM_NOP, 5'h08, 1'b1});
    `CHK("history", n0 + 1, n_req)
    results();
  end
  // watchdog: the sequence needs a small fraction of this span
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    err_total++;
    results();
  end
endmodule : test_system_probe_command_receiver
`default_nettype wire
